//--- include/sbp_pkg.sv
// package of constants and types for the static branch predictor with return stack
// ****************************************
// Overview of operation
// ****************************************
// Overview of operation
// - no btb history uses static; dynamic wins
// - unconditional branches predicted taken to target
// - indirect branches statically predicted not taken
// - direction mode: backward conditional predicted taken
// - direction mode: forward conditional predicted not taken
// - alternative mode: conditionals always dynamically predicted
// - indirect hit replaces fall-through with hardware target
// - indirect target is most recent taken actual target
// - one taken target per indirect entry
// - sixteen entry return stack supplies return targets
// - trace prediction overrides stack when still valid
// - undefined opcode after indirect table miss stops fall-through decode
// - pause is architectural nop, spin-wait hint
package sbp_pkg;
    localparam int ADDR_W = 32;
    localparam int RAS_DEPTH = 16;
    localparam int RAS_PTR_W = 4;
    localparam int ITB_ENTRIES = 64;
    localparam int ITB_IDX_W = 6;
    localparam int ITB_IDX_LSB = 2;
    localparam int ITB_TAG_W = ADDR_W - ITB_IDX_W - ITB_IDX_LSB;
    localparam logic [RAS_PTR_W:0] RAS_COUNT_FULL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;

    typedef enum logic [6:0]
    {
        SBP_KIND_NONE = 7'h01,
        SBP_KIND_UNCOND = 7'h02,
        SBP_KIND_COND = 7'h04,
        SBP_KIND_INDIRECT = 7'h08,
        SBP_KIND_CALL = 7'h10,
        SBP_KIND_INDCALL = 7'h20,
        SBP_KIND_RETURN = 7'h40
    } sbp_kind_type;
endpackage

//--- logic/sbp_predictor.sv
// static predictor, indirect target table and return address stack
`timescale 1ns/1ps
module sbp_predictor
(
    input wire logic clock, // core clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic direction_mode, // 1: static by jump direction, 0: conditionals always dynamic
    input wire logic req_valid, // branch presented for prediction
    input wire sbp_pkg::sbp_kind_type req_kind, // branch class
    input wire logic [sbp_pkg::ADDR_W-1:0] req_pc, // branch address
    input wire logic [sbp_pkg::ADDR_W-1:0] req_seq_pc, // next sequential address
    input wire logic [sbp_pkg::ADDR_W-1:0] req_target, // decoded direct target
    input wire logic dyn_hit, // dynamic history exists
    input wire logic dyn_taken, // dynamic direction
    input wire logic trace_valid, // trace holds prediction for this return
    input wire logic [sbp_pkg::ADDR_W-1:0] trace_target, // trace predicted target
    input wire logic next_is_undef, // undefined opcode follows this branch
    input wire logic req_is_pause, // spin-wait hint seen
    input wire logic upd_valid, // resolved indirect branch
    input wire logic [sbp_pkg::ADDR_W-1:0] upd_pc, // its address
    input wire logic [sbp_pkg::ADDR_W-1:0] upd_target, // its actual target
    input wire logic upd_taken, // it left the fall-through path
    input wire logic loop_exit, // spin loop exit seen by memory order logic
    output logic pred_valid, // prediction valid
    output logic pred_taken, // predicted taken
    output logic [sbp_pkg::ADDR_W-1:0] pred_target, // predicted fetch address
    output logic pred_used_static, // static algorithm chose
    output logic stop_decode, // halt decode of fall-through path
    output logic spin_hint, // spin-wait hint active
    output logic [sbp_pkg::RAS_PTR_W:0] ras_count // return stack occupancy
);
    import sbp_pkg::*;

    // ****************************************
    // indirect target table
    // ****************************************
    logic [ADDR_W-1:0] itb_target [ITB_ENTRIES];
    logic [ITB_TAG_W-1:0] itb_tag [ITB_ENTRIES];
    logic [ITB_ENTRIES-1:0] itb_valid;

    function automatic logic [ITB_IDX_W-1:0] itb_index(input logic [ADDR_W-1:0] a);
        return a[ITB_IDX_LSB +: ITB_IDX_W];
    endfunction

    function automatic logic [ITB_TAG_W-1:0] itb_tagof(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: ITB_TAG_W];
    endfunction

    wire [ITB_IDX_W-1:0] rd_idx = itb_index(req_pc);
    wire [ITB_IDX_W-1:0] wr_idx = itb_index(upd_pc);
    wire itb_hit = itb_valid[rd_idx] && (itb_tag[rd_idx] == itb_tagof(req_pc));

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            itb_valid <= '0;
        else if (upd_valid && upd_taken)
            itb_valid[wr_idx] <= 1'b1;
    end

    // single target slot, overwritten by the latest taken target
    always_ff @(posedge clock)
    begin
        if (upd_valid && upd_taken)
        begin
            itb_target[wr_idx] <= upd_target;
            itb_tag[wr_idx] <= itb_tagof(upd_pc);
        end
    end

    // ****************************************
    // return address stack
    // ****************************************
    logic [ADDR_W-1:0] ras_mem [RAS_DEPTH];
    logic [RAS_PTR_W-1:0] ras_top;

    wire is_call = req_valid && (req_kind == SBP_KIND_CALL || req_kind == SBP_KIND_INDCALL);
    wire is_ret = req_valid && (req_kind == SBP_KIND_RETURN);
    wire ras_empty = (ras_count == '0);
    wire [RAS_PTR_W-1:0] ras_rd_ptr = ras_top - 4'h1;
    wire [ADDR_W-1:0] ras_pop_addr = ras_mem[ras_rd_ptr];

    // circular: overflow drops the oldest entry, deep nesting then mispredicts
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ras_top <= '0;
            ras_count <= '0;
        end
        else if (is_call)
        begin
            ras_top <= ras_top + 4'h1;
            if (ras_count != RAS_COUNT_FULL)
                ras_count <= ras_count + 5'h01;
        end
        else if (is_ret && !ras_empty)
        begin
            ras_top <= ras_rd_ptr;
            ras_count <= ras_count - 5'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (is_call)
            ras_mem[ras_top] <= req_seq_pc;
    end

    // ****************************************
    // prediction selection
    // ****************************************
    wire is_backward = (req_target <= req_pc);
    wire cond_static_taken = direction_mode && is_backward;
    wire cond_use_static = direction_mode && !dyn_hit;
    wire cond_taken = cond_use_static ? cond_static_taken : dyn_taken;
    wire ret_target_ok = trace_valid || !ras_empty;
    wire [ADDR_W-1:0] ret_target = trace_valid ? trace_target : ras_pop_addr;

    logic next_taken;
    logic next_static;
    logic [ADDR_W-1:0] next_target;

    always_comb
    begin
        next_taken = 1'b0;
        next_static = 1'b0;
        next_target = req_seq_pc;
        case (req_kind)
            SBP_KIND_UNCOND, SBP_KIND_CALL:
            begin
                next_taken = 1'b1;
                next_static = !dyn_hit;
                next_target = req_target;
            end
            SBP_KIND_COND:
            begin
                next_taken = cond_taken;
                next_static = cond_use_static;
                next_target = cond_taken ? req_target : req_seq_pc;
            end
            SBP_KIND_INDIRECT, SBP_KIND_INDCALL:
            begin
                next_taken = itb_hit;
                next_static = !itb_hit;
                next_target = itb_hit ? itb_target[rd_idx] : req_seq_pc;
            end
            SBP_KIND_RETURN:
            begin
                next_taken = ret_target_ok;
                next_static = 1'b0;
                next_target = ret_target_ok ? ret_target : req_seq_pc;
            end
            default:
            begin
                next_taken = 1'b0;
            end
        endcase
    end

    wire is_indirect = req_kind == SBP_KIND_INDIRECT || req_kind == SBP_KIND_INDCALL;
    wire next_stop = req_valid && is_indirect && next_is_undef && !itb_hit;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pred_valid <= 1'b0;
            pred_taken <= 1'b0;
            pred_target <= ADDR_ZERO;
            pred_used_static <= 1'b0;
            stop_decode <= 1'b0;
        end
        else
        begin
            pred_valid <= req_valid && req_kind != SBP_KIND_NONE;
            pred_taken <= req_valid && next_taken;
            pred_target <= next_target;
            pred_used_static <= req_valid && next_static;
            stop_decode <= next_stop;
        end
    end

    // ****************************************
    // spin-wait hint
    // ****************************************
    // no architectural state changes; only tells memory order logic to be gentle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            spin_hint <= 1'b0;
        else if (req_is_pause)
            spin_hint <= 1'b1;
        else if (loop_exit)
            spin_hint <= 1'b0;
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_uncond_taken: assert property (
        req_valid && req_kind == SBP_KIND_UNCOND
        |=> pred_taken && pred_target == $past(req_target))
        else $error("unconditional branch not predicted taken");
    a_indirect_miss: assert property (
        req_valid && req_kind == SBP_KIND_INDIRECT && !itb_hit
        |=> !pred_taken && pred_target == $past(req_seq_pc))
        else $error("indirect miss not fall-through");
    a_back_taken: assert property (
        req_valid && req_kind == SBP_KIND_COND && direction_mode && !dyn_hit && req_target <= req_pc
        |=> pred_taken)
        else $error("backward conditional not taken");
    a_fwd_nottaken: assert property (
        req_valid && req_kind == SBP_KIND_COND && direction_mode && !dyn_hit && req_target > req_pc
        |=> !pred_taken)
        else $error("forward conditional taken");
    a_always_dynamic: assert property (
        req_valid && req_kind == SBP_KIND_COND && !direction_mode
        |=> pred_taken == $past(dyn_taken) && !pred_used_static)
        else $error("alternative mode used static");
    // quiet middle cycle: no second update may overwrite the slot before the lookup
    a_indirect_latest: assert property (
        upd_valid && upd_taken ##1 !upd_valid ##1
        req_valid && req_kind == SBP_KIND_INDIRECT && req_pc == $past(upd_pc, 2)
        |=> pred_taken && pred_target == $past(upd_target, 3))
        else $error("indirect target not latest");
    a_call_return: assert property (
        is_call ##1 !req_valid ##1 is_ret && !trace_valid
        |=> pred_taken && pred_target == $past(req_seq_pc, 3))
        else $error("return target not pushed address");
    a_ras_bound: assert property (
        is_call && ras_count == RAS_COUNT_FULL |=> ras_count == RAS_COUNT_FULL)
        else $error("return stack count overflow");
    a_undef_stop: assert property (
        req_valid && req_kind == SBP_KIND_INDIRECT && next_is_undef && !itb_hit
        |=> stop_decode)
        else $error("decode not stopped");
    a_pause_hint: assert property (
        req_is_pause |=> spin_hint)
        else $error("pause hint missing");
    a_trace_ret: assert property (
        is_ret && trace_valid |=> pred_taken && pred_target == $past(trace_target))
        else $error("trace return target ignored");

    c_static_back: cover property (
        req_valid && req_kind == SBP_KIND_COND && direction_mode && !dyn_hit ##1 pred_taken);
    c_indirect_hit: cover property (req_valid && req_kind == SBP_KIND_INDIRECT && itb_hit);
    c_ras_full: cover property (ras_count == RAS_COUNT_FULL);
    c_undef_stop: cover property (stop_decode);
endmodule

//--- testbench/sbp_pipe_model.sv
// pipeline-side model that offers branches to the predictor
`timescale 1ns/1ps
module sbp_pipe_model
(
    input wire logic clock, // core clock
    output logic req_valid, // branch offered
    output sbp_pkg::sbp_kind_type req_kind, // branch class
    output logic [sbp_pkg::ADDR_W-1:0] req_pc, // branch address
    output logic [sbp_pkg::ADDR_W-1:0] req_seq_pc, // next sequential address
    output logic [sbp_pkg::ADDR_W-1:0] req_target, // decoded target
    output logic dyn_hit, // history present
    output logic dyn_taken // history direction
);
    import sbp_pkg::*;
    int depth = 0;
    initial
    begin
        req_valid = 1'h0;
        req_kind = SBP_KIND_NONE;
        req_pc = 32'h0;
        req_seq_pc = 32'h0;
        req_target = 32'h0;
        dyn_hit = 1'h0;
        dyn_taken = 1'h0;
    end
    // one branch per call, held for exactly one rising edge
    task automatic branch(input sbp_kind_type k, input logic [31:0] pc, tgt, input logic dh, dt);
        @(negedge clock);
        if (k == SBP_KIND_CALL)
            depth++;
        if (k == SBP_KIND_RETURN && depth > 0)
            depth--;
        req_valid = 1'h1;
        req_kind = k;
        req_pc = pc;
        req_seq_pc = pc + 32'h4;
        req_target = tgt;
        dyn_hit = dh;
        dyn_taken = dt;
        @(negedge clock);
        req_valid = 1'h0;
        // released address and target lines no longer carry the old value; kind, seq pc and history keep it
        req_pc = ~pc;
        req_target = ~tgt;
    endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the static predictor and return stack
`timescale 1ns/1ps
module tb;
    import sbp_pkg::*;
    logic clock, sys_rst, direction_mode, req_valid, dyn_hit, dyn_taken, trace_valid;
    logic next_is_undef, req_is_pause, upd_valid, upd_taken, loop_exit;
    logic pred_valid, pred_taken, pred_used_static, stop_decode, spin_hint;
    logic [ADDR_W-1:0] req_pc, req_seq_pc, req_target, trace_target, upd_pc, upd_target, pred_target;
    logic [RAS_PTR_W:0] ras_count;
    sbp_kind_type req_kind;
    int error_cnt = 0;
    int comparisons = 0;
    sbp_predictor i_sbp_predictor (.clock, .sys_rst, .direction_mode, .req_valid, .req_kind, .req_pc,
        .req_seq_pc, .req_target, .dyn_hit, .dyn_taken, .trace_valid, .trace_target, .next_is_undef,
        .req_is_pause, .upd_valid, .upd_pc, .upd_target, .upd_taken, .loop_exit, .pred_valid,
        .pred_taken, .pred_target, .pred_used_static, .stop_decode, .spin_hint, .ras_count);
    sbp_pipe_model i_sbp_pipe_model (.clock, .req_valid, .req_kind, .req_pc, .req_seq_pc,
        .req_target, .dyn_hit, .dyn_taken);
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pr(input sbp_kind_type k, input logic [31:0] pc, tgt, input logic dh, dt, et,
        input logic [31:0] etg);
        i_sbp_pipe_model.branch(k, pc, tgt, dh, dt);
        chk(pred_valid, 1'h1);
        chk(pred_taken, et);
        chk(pred_target, etg);
    endtask
    task automatic upd(input logic [31:0] pc, tgt, input logic tk);
        @(negedge clock);
        upd_valid = 1'h1;
        upd_pc = pc;
        upd_target = tgt;
        upd_taken = tk;
        @(negedge clock);
        upd_valid = 1'h0;
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_static;
        pr(SBP_KIND_UNCOND, 32'h100, 32'h400, 1'h0, 1'h0, 1'h1, 32'h400);
        chk(pred_used_static, 1'h1);
        pr(SBP_KIND_UNCOND, 32'h100, 32'h40, 1'h1, 1'h0, 1'h1, 32'h40);
        chk(pred_used_static, 1'h0);
        pr(SBP_KIND_COND, 32'h100, 32'h80, 1'h0, 1'h0, 1'h1, 32'h80);
        pr(SBP_KIND_COND, 32'h100, 32'h100, 1'h0, 1'h0, 1'h1, 32'h100);
        pr(SBP_KIND_COND, 32'h100, 32'h108, 1'h0, 1'h1, 1'h0, 32'h104);
        chk(pred_used_static, 1'h1);
        pr(SBP_KIND_COND, 32'h100, 32'h80, 1'h1, 1'h0, 1'h0, 32'h104);
        chk(pred_used_static, 1'h0);
        pr(SBP_KIND_INDIRECT, 32'h100, 32'h80, 1'h0, 1'h1, 1'h0, 32'h104);
        direction_mode = 1'h0;
        pr(SBP_KIND_COND, 32'h100, 32'h80, 1'h0, 1'h0, 1'h0, 32'h104);
        pr(SBP_KIND_COND, 32'h100, 32'h200, 1'h0, 1'h1, 1'h1, 32'h200);
        chk(pred_used_static, 1'h0);
        direction_mode = 1'h1;
    endtask
    // overflow past sixteen drops the oldest entry, then an empty pop falls through
    task automatic t_stack;
        for (int i = 1; i <= 17; i++)
        begin
            pr(SBP_KIND_CALL, 32'h1000 + i * 16, 32'h8000, 1'h0, 1'h0, 1'h1, 32'h8000);
            chk(ras_count, (i > 16) ? 16 : i);
        end
        for (int i = 17; i >= 2; i--)
            pr(SBP_KIND_RETURN, 32'h2000, 32'h0, 1'h0, 1'h0, 1'h1, 32'h1004 + i * 16);
        pr(SBP_KIND_RETURN, 32'h2000, 32'h0, 1'h0, 1'h0, 1'h0, 32'h2004);
        chk(ras_count, 32'h0);
        pr(SBP_KIND_CALL, 32'h400, 32'h900, 1'h0, 1'h0, 1'h1, 32'h900);
        trace_valid = 1'h1;
        pr(SBP_KIND_RETURN, 32'h950, 32'h0, 1'h0, 1'h0, 1'h1, 32'h3330);
        trace_valid = 1'h0;
    endtask
    // entries 0x300 and 0x600 share an index, so the tag must separate them
    task automatic t_indir;
        upd(32'h300, 32'h5000, 1'h1);
        pr(SBP_KIND_INDIRECT, 32'h300, 32'h0, 1'h0, 1'h0, 1'h1, 32'h5000);
        upd(32'h300, 32'h7000, 1'h1);
        next_is_undef = 1'h1;
        pr(SBP_KIND_INDIRECT, 32'h300, 32'h0, 1'h0, 1'h0, 1'h1, 32'h7000);
        chk(stop_decode, 1'h0);
        pr(SBP_KIND_INDIRECT, 32'h600, 32'h0, 1'h0, 1'h0, 1'h0, 32'h604);
        chk(stop_decode, 1'h1);
        next_is_undef = 1'h0;
        upd(32'h300, 32'h9000, 1'h0);
        pr(SBP_KIND_INDIRECT, 32'h300, 32'h0, 1'h0, 1'h0, 1'h1, 32'h7000);
        upd(32'h340, 32'h6000, 1'h1);
        pr(SBP_KIND_INDCALL, 32'h340, 32'h0, 1'h0, 1'h0, 1'h1, 32'h6000);
    endtask
    task automatic t_pause;
        @(negedge clock);
        req_is_pause = 1'h1;
        loop_exit = 1'h1;
        @(negedge clock);
        req_is_pause = 1'h0;
        loop_exit = 1'h0;
        repeat (3) @(negedge clock);
        chk(spin_hint, 1'h1);
        chk(pred_valid, 1'h0);
        i_sbp_pipe_model.branch(SBP_KIND_NONE, 32'h500, 32'h0, 1'h0, 1'h0);
        chk(pred_valid, 1'h0);
        chk(spin_hint, 1'h1);
        loop_exit = 1'h1;
        @(negedge clock);
        loop_exit = 1'h0;
        chk(spin_hint, 1'h0);
    endtask
    initial
    begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        #20000;
        error_cnt++;
        test_done;
    end
    initial
    begin
        {sys_rst, direction_mode} = 2'h3;
        {trace_valid, next_is_undef, req_is_pause, upd_valid, upd_taken, loop_exit} = 6'h0;
        {trace_target, upd_pc, upd_target} = {32'h3330, 64'h0};
        repeat (5) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'h0;
        chk({pred_valid, pred_taken, stop_decode, spin_hint, ras_count}, 32'h0);
        t_static;
        t_stack;
        t_indir;
        t_pause;
        test_done;
    end
endmodule
